// >>> design/sevg_top.sv
// system event vector generators with debug mailbox and interrupt
// How it works
// [R1] power-on causes coded 0Ch to 14h at 019Eh
// [R2] brownout causes 02h,04h,06h,0Ah; 08h unused; the code puts 04h in the power-on class
// [R3] watchdog expiry 16h, password 18h, clear class
// [R4] flash password 1Ah clear class; 1Ch unused
// [R5] peripheral area fetch coded 1Eh, clear class
// [R6] power unit password violation coded 20h
// [R7] lower code wins; zero when nothing pending
// [R8] system vector 019Ch codes 02h to 0Ah
// [R9] mailbox, regulator codes 0Ch to 12h
// [R10] user vector 019Ah codes 02h,04h,06h
// [R11] user codes above 06h never returned
// [R12] mailbox traffic raises system vector flags
// [R13] each reset cause mapped to its class
// [R14] reading a vector clears reported flag
// [R15] vectors 16-bit read-only, writes ignored
`include "sevg_cfg.svh"
module sevg_top (
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic [`SEVG_AW-1:0]     addr_i,
  input  wire logic [`SEVG_DW-1:0]     wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [`SEVG_DW-1:0]     rdata_o,
  input  wire logic [`SEVG_RST_N-1:0]  rst_cause_ev_i,
  input  wire logic [`SEVG_SNMI_N-1:0] snmi_ev_i,
  input  wire logic [`SEVG_UNMI_N-1:0] unmi_ev_i,
  input  wire logic                    dbg_wr_i,
  input  wire logic [`SEVG_DW-1:0]     dbg_wdata_i,
  input  wire logic                    dbg_rd_i,
  output logic      [`SEVG_DW-1:0]     dbg_rdata_o,
  output logic                         irq_o,
  output logic                         bor_req_o,
  output logic                         por_req_o,
  output logic                         puc_req_o
);
  sevg_pkg::sevg_state_s st_q;
  sevg_pkg::sevg_state_s st_d;

  logic [`SEVG_RST_N-1:0]  rst_hit;
  logic [`SEVG_SNMI_N-1:0] snmi_hit;
  logic [`SEVG_UNMI_N-1:0] unmi_hit;
  logic [`SEVG_DW-1:0]     rst_code;
  logic [`SEVG_DW-1:0]     snmi_code;
  logic [`SEVG_DW-1:0]     unmi_code;
  logic [`SEVG_RST_N-1:0]  rst_ev;
  logic [`SEVG_SNMI_N-1:0] snmi_ev;
  logic [`SEVG_IRQ_N-1:0]  grp_ev;
  logic                    rd_rst;
  logic                    rd_snmi;
  logic                    rd_unmi;

  sevg_prienc #(.N(`SEVG_RST_N), .W(`SEVG_DW)) u_rst (
    .flags_i (st_q.rst_flags),
    .hit_o   (rst_hit),
    .code_o  (rst_code)
  );
  sevg_prienc #(.N(`SEVG_SNMI_N), .W(`SEVG_DW)) u_snmi (
    .flags_i (st_q.snmi_flags),
    .hit_o   (snmi_hit),
    .code_o  (snmi_code)
  );
  sevg_prienc #(.N(`SEVG_UNMI_N), .W(`SEVG_DW)) u_unmi (
    .flags_i (st_q.unmi_flags),
    .hit_o   (unmi_hit),
    .code_o  (unmi_code)
  );

  assign rst_ev  = rst_cause_ev_i & ~`SEVG_RST_RSV_MASK; // [R2] [R4]
  always_comb begin
    snmi_ev = snmi_ev_i & ~`SEVG_SNMI_MB_MASK;
    snmi_ev[`SEVG_SNMI_MBIN]  = dbg_wr_i; // [R12]
    snmi_ev[`SEVG_SNMI_MBOUT] = dbg_rd_i; // [R12]
  end
  assign grp_ev  = {|unmi_ev_i, |snmi_ev, |rst_ev};
  assign rd_rst  = rd_i && (addr_i == `SEVG_ADDR_RST);
  assign rd_snmi = rd_i && (addr_i == `SEVG_ADDR_SNMI);
  assign rd_unmi = rd_i && (addr_i == `SEVG_ADDR_UNMI);

  always_comb begin
    st_d = st_q;
    st_d.rdata = `SEVG_ZERO16;
    // read clears the reported flag, a new event in the same cycle wins
    st_d.rst_flags = (st_q.rst_flags & ~(rd_rst ? rst_hit : '0))
                     | rst_ev; // [R14] [R1] [R3] [R5] [R6]
    st_d.snmi_flags = (st_q.snmi_flags & ~(rd_snmi ? snmi_hit : '0))
                      | snmi_ev; // [R14] [R8] [R9]
    st_d.unmi_flags = (st_q.unmi_flags & ~(rd_unmi ? unmi_hit : '0))
                      | unmi_ev_i; // [R14] [R10]
    if (rd_i) begin
      unique case (addr_i)
        `SEVG_ADDR_RST:   st_d.rdata = rst_code;  // [R7] [R15]
        `SEVG_ADDR_SNMI:  st_d.rdata = snmi_code; // [R9]
        `SEVG_ADDR_UNMI:  st_d.rdata = unmi_code; // [R11]
        `SEVG_ADDR_STAT:  st_d.rdata = `SEVG_DW'(st_q.irq_stat);
        `SEVG_ADDR_MASK:  st_d.rdata = `SEVG_DW'(st_q.irq_mask);
        `SEVG_ADDR_MBIN:  st_d.rdata = st_q.mbox_in;
        `SEVG_ADDR_MBOUT: st_d.rdata = st_q.mbox_out;
        default:          st_d.rdata = `SEVG_ZERO16;
      endcase
    end
    st_d.irq_stat = st_q.irq_stat;
    if (wr_i) begin
      unique case (addr_i)
        `SEVG_ADDR_STAT:  st_d.irq_stat = st_q.irq_stat
                                          & ~wdata_i[`SEVG_IRQ_N-1:0];
        `SEVG_ADDR_MASK:  st_d.irq_mask = wdata_i[`SEVG_IRQ_N-1:0];
        `SEVG_ADDR_MBOUT: st_d.mbox_out = wdata_i;
        default:          st_d.mbox_out = st_q.mbox_out; // [R15]
      endcase
    end
    st_d.irq_stat = st_d.irq_stat | grp_ev;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
    if (dbg_wr_i) begin
      st_d.mbox_in = dbg_wdata_i; // [R12]
    end
    st_d.dbg_rdata = dbg_rd_i ? st_q.mbox_out : st_q.dbg_rdata; // [R12]
    // the most severe class among this cycle's causes is requested
    st_d.bor = |(rst_ev & `SEVG_RST_BOR_MASK); // [R13] [R2]
    st_d.por = !st_d.bor && |(rst_ev & `SEVG_RST_POR_MASK); // [R13] [R1]
    st_d.power_up_clear_class = !st_d.bor && !st_d.por
               && |(rst_ev & `SEVG_RST_PUC_MASK); // [R13] [R3]
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o     = st_q.rdata;
  assign dbg_rdata_o = st_q.dbg_rdata;
  assign irq_o       = st_q.irq;
  assign bor_req_o   = st_q.bor;
  assign por_req_o   = st_q.por;
  assign puc_req_o   = st_q.power_up_clear_class;

  property p_rst_top;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[0]) |=> (rdata_o == 16'h0002);
  endproperty
  a_rst_top: assert property (p_rst_top) // [R2]
    else $error("brownout not reported as top reset cause");

  property p_rst_none;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags == '0) |=> (rdata_o == 16'h0000);
  endproperty
  a_rst_none: assert property (p_rst_none) // [R7]
    else $error("empty reset vector not zero");

  property p_rst_rsv;
    @(posedge clk_i) disable iff (!rst_b_i)
      rst_cause_ev_i[3] |=> (st_q.rst_flags[3] == $past(st_q.rst_flags[3]));
  endproperty
  a_rst_rsv: assert property (p_rst_rsv) // [R2]
    else $error("reserved reset cause got set");

  property p_rst_range;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[15] && st_q.rst_flags[14:0] == '0)
        |=> (rdata_o == 16'h0020);
  endproperty
  a_rst_range: assert property (p_rst_range) // [R6]
    else $error("power unit password code wrong");

  property p_read_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && rst_hit[10] && !rst_cause_ev_i[10])
        |=> (!st_q.rst_flags[10] && rdata_o == 16'h0016);
  endproperty
  a_read_clear: assert property (p_read_clear) // [R14]
    else $error("watchdog cause not cleared by read");

  property p_snmi_top;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_snmi && st_q.snmi_flags[0]) |=> (rdata_o == 16'h0002);
  endproperty
  a_snmi_top: assert property (p_snmi_top) // [R8]
    else $error("system vector priority wrong");

  property p_unmi_bound;
    @(posedge clk_i) disable iff (!rst_b_i)
      rd_unmi |=> (rdata_o <= 16'h0006 && rdata_o[0] == 1'b0);
  endproperty
  a_unmi_bound: assert property (p_unmi_bound) // [R11]
    else $error("user vector out of range");

  property p_mbox;
    @(posedge clk_i) disable iff (!rst_b_i)
      dbg_wr_i |=> (st_q.snmi_flags[`SEVG_SNMI_MBIN]
                    && st_q.mbox_in == $past(dbg_wdata_i));
  endproperty
  a_mbox: assert property (p_mbox) // [R12]
    else $error("mailbox input flag not raised");

  property p_bor_class;
    @(posedge clk_i) disable iff (!rst_b_i)
      rst_cause_ev_i[0] |=> (bor_req_o && !por_req_o && !puc_req_o);
  endproperty
  a_bor_class: assert property (p_bor_class) // [R13]
    else $error("brownout class not applied");

  property p_puc_class;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rst_cause_ev_i[11] && (rst_ev & 16'h03FF) == '0)
        |=> (puc_req_o && !bor_req_o);
  endproperty
  a_puc_class: assert property (p_puc_class) // [R3]
    else $error("watchdog password not clear class");

  property p_wr_ignored;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wr_i && addr_i == `SEVG_ADDR_RST && rst_ev == '0)
        |=> (st_q.rst_flags == $past(st_q.rst_flags));
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) // [R15]
    else $error("write changed reset vector");

  property p_rst_pin;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[1:0] == 2'b10) |=> (rdata_o == 16'h0004);
  endproperty
  a_rst_pin: assert property (p_rst_pin) // [R2]
    else $error("reset pin cause code wrong");

  property p_rst_sec;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[4] && st_q.rst_flags[3:0] == '0)
        |=> (rdata_o == 16'h000A);
  endproperty
  a_rst_sec: assert property (p_rst_sec) // [R2]
    else $error("security violation code wrong");

  property p_rst_svs;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[5] && st_q.rst_flags[4:0] == '0)
        |=> (rdata_o == 16'h000C);
  endproperty
  a_rst_svs: assert property (p_rst_svs) // [R1]
    else $error("low side supervisor code wrong");

  property p_rst_sw_por;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[9] && st_q.rst_flags[8:0] == '0)
        |=> (rdata_o == 16'h0014);
  endproperty
  a_rst_sw_por: assert property (p_rst_sw_por) // [R1]
    else $error("software power-on code wrong");

  property p_rst_wdt_pw;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[11] && st_q.rst_flags[10:0] == '0)
        |=> (rdata_o == 16'h0018);
  endproperty
  a_rst_wdt_pw: assert property (p_rst_wdt_pw) // [R3]
    else $error("watchdog password code wrong");

  property p_rst_key;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[12] && st_q.rst_flags[11:0] == '0)
        |=> (rdata_o == 16'h001A);
  endproperty
  a_rst_key: assert property (p_rst_key) // [R4]
    else $error("flash password code wrong");

  property p_rst_fetch;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_rst && st_q.rst_flags[14] && st_q.rst_flags[13:0] == '0)
        |=> (rdata_o == 16'h001E);
  endproperty
  a_rst_fetch: assert property (p_rst_fetch) // [R5]
    else $error("peripheral fetch code wrong");

  property p_rst_rsv_hi;
    @(posedge clk_i) disable iff (!rst_b_i)
      rst_cause_ev_i[13] |=> !st_q.rst_flags[13];
  endproperty
  a_rst_rsv_hi: assert property (p_rst_rsv_hi) // [R4]
    else $error("reserved high reset cause got set");

  property p_snmi_last;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_snmi && st_q.snmi_flags[8] && st_q.snmi_flags[7:0] == '0)
        |=> (rdata_o == 16'h0012);
  endproperty
  a_snmi_last: assert property (p_snmi_last) // [R9]
    else $error("high side regulator code wrong");

  property p_snmi_mbout;
    @(posedge clk_i) disable iff (!rst_b_i)
      dbg_rd_i |=> (st_q.snmi_flags[`SEVG_SNMI_MBOUT]
                    && dbg_rdata_o == $past(st_q.mbox_out));
  endproperty
  a_snmi_mbout: assert property (p_snmi_mbout) // [R12]
    else $error("mailbox output flag not raised");

  property p_unmi_top;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_unmi && st_q.unmi_flags[0]) |=> (rdata_o == 16'h0002);
  endproperty
  a_unmi_top: assert property (p_unmi_top) // [R10]
    else $error("user vector priority wrong");

  property p_unmi_osc;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_unmi && st_q.unmi_flags[1:0] == 2'b10) |=> (rdata_o == 16'h0004);
  endproperty
  a_unmi_osc: assert property (p_unmi_osc) // [R10]
    else $error("oscillator fault code wrong");

  property p_por_class;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rst_cause_ev_i[5] && (rst_ev & `SEVG_RST_BOR_MASK) == '0)
        |=> (por_req_o && !bor_req_o && !puc_req_o);
  endproperty
  a_por_class: assert property (p_por_class) // [R13]
    else $error("power-on class not applied");
endmodule

// >>> design/sevg_cfg.svh
// constants of the system event vector generators
`ifndef SEVG_CFG_SVH
`define SEVG_CFG_SVH
`define SEVG_AW           16
`define SEVG_DW           16
`define SEVG_ADDR_UNMI    16'h019A
`define SEVG_ADDR_SNMI    16'h019C
`define SEVG_ADDR_RST     16'h019E
`define SEVG_ADDR_STAT    16'h01A0
`define SEVG_ADDR_MASK    16'h01A2
`define SEVG_ADDR_MBIN    16'h01A4
`define SEVG_ADDR_MBOUT   16'h01A6
`define SEVG_RST_N        16
`define SEVG_SNMI_N       9
`define SEVG_UNMI_N       3
`define SEVG_IRQ_N        3
`define SEVG_IRQ_RST      0
`define SEVG_IRQ_SNMI     1
`define SEVG_IRQ_UNMI     2
`define SEVG_RST_BOR_MASK 16'h0015
`define SEVG_RST_POR_MASK 16'h03E2
`define SEVG_RST_PUC_MASK 16'hDC00
`define SEVG_RST_RSV_MASK 16'h2008
`define SEVG_SNMI_MBIN    5
`define SEVG_SNMI_MBOUT   6
`define SEVG_SNMI_MB_MASK 9'h060
`define SEVG_ZERO16       16'h0000
`endif

// >>> design/sevg_pkg.sv
// types of the system event vector generators
`include "sevg_cfg.svh"
package sevg_pkg;
  typedef struct packed {
    logic [`SEVG_RST_N-1:0]  rst_flags;
    logic [`SEVG_SNMI_N-1:0] snmi_flags;
    logic [`SEVG_UNMI_N-1:0] unmi_flags;
    logic [`SEVG_IRQ_N-1:0]  irq_stat;
    logic [`SEVG_IRQ_N-1:0]  irq_mask;
    logic [`SEVG_DW-1:0]     mbox_in;
    logic [`SEVG_DW-1:0]     mbox_out;
    logic [`SEVG_DW-1:0]     rdata;
    logic [`SEVG_DW-1:0]     dbg_rdata;
    logic                    irq;
    logic                    bor;
    logic                    por;
    logic                    power_up_clear_class;
  } sevg_state_s;
endpackage

// >>> design/sevg_prienc.sv
// priority encoder: lowest set index wins, code is twice index plus two
module sevg_prienc #(
  parameter int N = 16,
  parameter int W = 16
) (
  input  wire logic [N-1:0] flags_i,
  output logic      [N-1:0] hit_o,
  output logic      [W-1:0] code_o
);
  logic [N:0] seen;
  assign seen[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      assign hit_o[g]  = flags_i[g] & ~seen[g];
      assign seen[g+1] = seen[g] | flags_i[g];
    end
  endgenerate
  always_comb begin
    code_o = '0;
    if (seen[N]) begin
      for (int i = 0; i < N; i++) begin
        if (hit_o[i]) begin
          code_o = W'((i + 1) * 2);
        end
      end
    end
  end
endmodule

// >>> tb/test_system_event_vector_generators.sv
// self-checking bench for the system event vector generators
`include "sevg_cfg.svh"
module test_system_event_vector_generators;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] rst_cause_ev_i = 16'h0000;
  logic [8:0]  snmi_ev_i = 9'h000;
  logic [2:0]  unmi_ev_i = 3'h0;
  logic        dbg_wr_i = 1'b0;
  logic [15:0] dbg_wdata_i = 16'h0000;
  logic        dbg_rd_i = 1'b0;
  logic [15:0] dbg_rdata_o;
  logic        irq_o, bor_req_o, por_req_o, puc_req_o;
  logic [15:0] mdl [3];
  logic [31:0] seed = 32'h0992;
  int          fail_count = 0;
  int          comparisons = 0;
  always #2 clk_i = ~clk_i;
  sevg_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rst_cause_ev_i(rst_cause_ev_i), .snmi_ev_i(snmi_ev_i),
    .unmi_ev_i(unmi_ev_i), .dbg_wr_i(dbg_wr_i), .dbg_wdata_i(dbg_wdata_i),
    .dbg_rd_i(dbg_rd_i), .dbg_rdata_o(dbg_rdata_o), .irq_o(irq_o),
    .bor_req_o(bor_req_o), .por_req_o(por_req_o), .puc_req_o(puc_req_o));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic ev(input logic [15:0] r, input logic [8:0] s,
                    input logic [2:0] u);
    logic b, p, c;
    b = |(r & `SEVG_RST_BOR_MASK);
    p = !b && |(r & `SEVG_RST_POR_MASK);
    c = !b && !p && |(r & `SEVG_RST_PUC_MASK);
    @(posedge clk_i);
    rst_cause_ev_i <= r; snmi_ev_i <= s; unmi_ev_i <= u;
    @(posedge clk_i);
    rst_cause_ev_i <= 16'h0000; snmi_ev_i <= 9'h000; unmi_ev_i <= 3'h0;
    #1 chk({13'h0, bor_req_o, por_req_o, puc_req_o}, {13'h0, b, p, c});
    mdl[0] = mdl[0] | (r & ~`SEVG_RST_RSV_MASK);
    mdl[1] = mdl[1] | {7'h0, s & ~`SEVG_SNMI_MB_MASK};
    mdl[2] = mdl[2] | {13'h0, u};
  endtask
  task automatic drain(input int k);
    logic [15:0] a, e, d;
    int          idx;
    a = (k == 0) ? `SEVG_ADDR_RST : (k == 1) ? `SEVG_ADDR_SNMI
                                             : `SEVG_ADDR_UNMI;
    for (int n = 0; n < 17; n++) begin
      idx = -1;
      for (int i = 15; i >= 0; i--) if (mdl[k][i]) idx = i;
      e = (idx < 0) ? 16'h0000 : 16'(2 * (idx + 1));
      if (idx >= 0) mdl[k][idx] = 1'b0;
      rd(a, d);
      chk(d, e);
    end
  endtask
  initial begin
    logic [15:0] d;
    mdl[0] = 16'h0000; mdl[1] = 16'h0000; mdl[2] = 16'h0000;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 3; k++) drain(k);
    for (int i = 0; i < 16; i++) ev(16'(1 << i), 9'(1 << (i % 9)), 3'h0);
    for (int k = 0; k < 3; k++) drain(k);
    for (int n = 0; n < 6; n++) begin
      seed = xs(seed);
      ev(seed[15:0], seed[24:16], seed[27:25]);
      wr(`SEVG_ADDR_RST, 16'hFFFF);
      wr(`SEVG_ADDR_SNMI, 16'hFFFF);
      wr(`SEVG_ADDR_UNMI, 16'hFFFF);
      for (int k = 0; k < 3; k++) drain(k);
    end
    rd(16'h0100, d);
    chk(d, 16'h0000);
    seed = xs(seed);
    @(posedge clk_i);
    dbg_wr_i <= 1'b1; dbg_wdata_i <= seed[15:0];
    @(posedge clk_i);
    dbg_wr_i <= 1'b0;
    rd(`SEVG_ADDR_MBIN, d);
    chk(d, seed[15:0]);
    wr(`SEVG_ADDR_MBOUT, seed[31:16]);
    @(posedge clk_i);
    dbg_rd_i <= 1'b1;
    @(posedge clk_i);
    dbg_rd_i <= 1'b0;
    #1 chk(dbg_rdata_o, seed[31:16]);
    mdl[1] = mdl[1] | 16'h0060;
    drain(1);
    wr(`SEVG_ADDR_STAT, 16'h0007);
    wr(`SEVG_ADDR_MASK, 16'h0004);
    ev(16'h0000, 9'h000, 3'h2);
    @(posedge clk_i);
    #1 chk({15'h0, irq_o}, 16'h0001);
    rd(`SEVG_ADDR_STAT, d);
    chk(d, 16'h0004);
    wr(`SEVG_ADDR_MASK, 16'h0003);
    repeat (2) @(posedge clk_i);
    #1 chk({15'h0, irq_o}, 16'h0000);
    wr(`SEVG_ADDR_MASK, 16'h0004);
    wr(`SEVG_ADDR_STAT, 16'h0004);
    repeat (2) @(posedge clk_i);
    #1 chk({15'h0, irq_o}, 16'h0000);
    drain(2);
    // mid-run reset drops every pending flag and request
    ev(16'hFFFF, 9'h1FF, 3'h7);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 3; k++) mdl[k] = 16'h0000;
    #1 chk({12'h0, irq_o, bor_req_o, por_req_o, puc_req_o}, 16'h0000);
    for (int k = 0; k < 3; k++) drain(k);
    summarize();
  end
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
